// [hw/timer2_waveform_output_control.sv]
/*
  timer2_waveform_output_control: 8-bit timer with waveform mode decode,
  two compare output channels, sticky event flags and one interrupt.
  Assumes a single clock mclk, a synchronous master on the register port
  and external circuitry resolving the pins from data and enable.
*/
`timescale 1ns/1ps
`include "timer2_params.svh"

module timer2_waveform_output_control
  import timer2_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic irq,
  output logic compare_pin_a,
  output logic compare_pin_a_oe,
  output logic compare_pin_b,
  output logic compare_pin_b_oe
);

  ctrl_a_t ctrl_a;
  logic waveform_mode_high_bit;
  logic [2:0] clk_sel;
  logic [2:0] waveform_mode;
  wave_kind_t kind;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic up;
  logic blk;
  logic [7:0] cmp [2];
  logic [7:0] cmp_buf [2];
  logic [7:0] top;
  logic run;
  logic at_top;
  logic at_bottom;
  logic load_buf;
  logic ovf_evt;
  logic [1:0] match;
  logic [1:0] force_evt;
  logic [2:0] flags;
  logic [2:0] irq_en;
  logic [1:0] port_data;
  logic [1:0] port_dir;
  logic [1:0] wave;
  logic [1:0] pin_q;
  logic [1:0] oe_q;
  logic [7:0] next_rdata;
  logic wr_b;
  logic wr_a;
  logic wr_count;
  logic wr_port;
  logic wr_clear;
  logic wr_irq_en;

  assign waveform_mode = {waveform_mode_high_bit,
                          ctrl_a.waveform_mode_low_bits};
  assign wr_b = wr && addr == `OFS_CTRL_B;
  assign wr_a = wr && addr == `OFS_CTRL_A;
  assign wr_count = wr && addr == `OFS_COUNT;
  assign wr_port = wr && addr == `OFS_PORT;
  assign wr_clear = wr && addr == `OFS_CLEAR;
  assign wr_irq_en = wr && addr == `OFS_IRQ_EN;

  // mode decode
  always_comb begin
    unique case (waveform_mode)
      3'h0: kind = kind_normal;
      3'h1: kind = kind_phase;
      3'h2: kind = kind_ctc;
      3'h3: kind = kind_fast;
      3'h4: kind = kind_reserved;
      3'h5: kind = kind_phase;
      3'h6: kind = kind_reserved;
      3'h7: kind = kind_fast;
    endcase
  end

  // TOP source
  always_comb begin
    if (waveform_mode == 3'h2 || waveform_mode == 3'h5 ||
        waveform_mode == 3'h7) begin
      top = cmp_buf[0];
    end else begin
      top = `CNT_MAX;
    end
  end

  // reserved modes hold the counter and raise no overflow or match events
  assign run = clk_sel != 3'h0 && kind != kind_reserved;
  assign at_top = cnt == top;
  assign at_bottom = cnt == `CNT_BOTTOM;

  // next count
  always_comb begin
    next_cnt = cnt;
    if (kind == kind_phase) begin
      if (up) begin
        next_cnt = at_top ? cnt - 8'h01 : cnt + 8'h01;
      end else begin
        next_cnt = at_bottom ? cnt + 8'h01 : cnt - 8'h01;
      end
    end else if (kind != kind_reserved) begin
      next_cnt = at_top ? `CNT_BOTTOM : cnt + 8'h01;
    end
  end

  // compare buffer load point
  always_comb begin
    unique case (kind)
      kind_fast: load_buf = run && at_top;
      kind_phase: load_buf = run && up && at_top;
      default: load_buf = 1'b1;
    endcase
  end

  // overflow event
  always_comb begin
    unique case (kind)
      kind_phase: ovf_evt = run && !up && at_bottom;
      kind_fast: ovf_evt = run && at_top;
      kind_reserved: ovf_evt = 1'b0;
      default: ovf_evt = run && cnt == `CNT_MAX;
    endcase
  end

  // counter and direction
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt <= `RST_BYTE;
      up <= 1'b1;
      blk <= 1'b0;
    end else if (wr_count) begin
      // the step after a count write compares nothing
      cnt <= wdata;
      blk <= 1'b1;
    end else begin
      if (run) begin
        cnt <= next_cnt;
        blk <= 1'b0;
      end
      if (kind != kind_phase) begin
        up <= 1'b1;
      end else if (run && up && at_top) begin
        up <= 1'b0;
      end else if (run && !up && at_bottom) begin
        up <= 1'b1;
      end
    end
  end

  // control registers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      ctrl_a <= ctrl_a_t'(`RST_BYTE);
      waveform_mode_high_bit <= 1'b0;
      clk_sel <= 3'h0;
    end else if (wr_a) begin
      ctrl_a <= ctrl_a_t'(wdata);
    end else if (wr_b) begin
      waveform_mode_high_bit <= wdata[`B_WGM_HI];
      clk_sel <= wdata[`B_CLK_SEL_HI:0];
    end
  end

  // port data and direction
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      port_data <= 2'h0;
      port_dir <= 2'h0;
    end else if (wr_port) begin
      port_data <= wdata[1:0];
      port_dir <= wdata[`B_PORT_DIR_LO +: 2];
    end
  end

  // per channel compare, waveform and pin
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      logic [1:0] com;
      logic top_skip;
      logic act_up;
      logic tog_ok;
      logic conn;
      logic [3:0] cmp_ofs;

      assign cmp_ofs = (ch == 0) ? `OFS_CMP_A : `OFS_CMP_B;
      assign com = (ch == 0) ? ctrl_a.output_mode_a
                             : ctrl_a.output_mode_b;
      // compare at TOP with the upper mode bit set: fast PWM waveform ignores the match
      assign top_skip = cmp_buf[ch] == top && com[1];
      assign act_up = up && !at_top;
      // value 1 in PWM toggles channel A only with the high bit set
      assign tog_ok = ch == 0 && waveform_mode_high_bit;
      assign match[ch] = run && !blk && cnt == cmp_buf[ch];
      assign force_evt[ch] = wr_b && kind != kind_fast &&
                             kind != kind_phase &&
                             wdata[`B_FORCE_A - ch];

      always_comb begin
        if (com == 2'h0) begin
          conn = 1'b0;
        end else if (com == 2'h1 &&
                     (kind == kind_fast || kind == kind_phase)) begin
          conn = tog_ok;
        end else begin
          conn = 1'b1;
        end
      end

      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          cmp[ch] <= `RST_BYTE;
        end else if (wr && addr == cmp_ofs) begin
          cmp[ch] <= wdata;
        end
      end

      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          cmp_buf[ch] <= `RST_BYTE;
        end else if (load_buf) begin
          cmp_buf[ch] <= cmp[ch];
        end
      end

      // waveform state runs whatever the pin routing
      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          wave[ch] <= 1'b0;
        end else if (kind == kind_fast) begin
          // the BOTTOM action lands on the step from TOP to zero
          if (run && at_top && com[1]) begin
            wave[ch] <= !com[0];
          end else if (match[ch] && !top_skip) begin
            if (com == 2'h1 && tog_ok) begin
              wave[ch] <= !wave[ch];
            end else if (com[1]) begin
              wave[ch] <= com[0];
            end
          end
        end else if (kind == kind_phase) begin
          // a match at TOP takes the down-counting action
          if (match[ch]) begin
            if (com == 2'h1 && tog_ok) begin
              wave[ch] <= !wave[ch];
            end else if (com[1]) begin
              wave[ch] <= act_up ? com[0] : !com[0];
            end
          end
        end else if (match[ch] || force_evt[ch]) begin
          unique case (com)
            2'h0: wave[ch] <= wave[ch];
            2'h1: wave[ch] <= !wave[ch];
            2'h2: wave[ch] <= 1'b0;
            2'h3: wave[ch] <= 1'b1;
          endcase
        end
      end

      always_ff @(posedge mclk) begin
        if (!rst_b) begin
          pin_q[ch] <= 1'b0;
          oe_q[ch] <= 1'b0;
        end else begin
          pin_q[ch] <= conn ? wave[ch] : port_data[ch];
          oe_q[ch] <= port_dir[ch];
        end
      end
    end
  endgenerate

  assign compare_pin_a = pin_q[0];
  assign compare_pin_a_oe = oe_q[0];
  assign compare_pin_b = pin_q[1];
  assign compare_pin_b_oe = oe_q[1];

  // sticky flags: a new event beats a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      flags <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (i == `B_OVF && ovf_evt) begin
          flags[i] <= 1'b1;
        end else if (i == `B_MATCH_A && match[0]) begin
          flags[i] <= 1'b1;
        end else if (i == `B_MATCH_B && match[1]) begin
          flags[i] <= 1'b1;
        end else if (wr_clear && wdata[i]) begin
          flags[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq_en <= 3'h0;
    end else if (wr_irq_en) begin
      irq_en <= wdata[2:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      // level output, one cycle behind the flags
      irq <= |(flags & irq_en);
    end
  end

  // read mux
  always_comb begin
    next_rdata = 8'h00;
    unique case (addr)
      `OFS_CTRL_A: begin
        next_rdata = ctrl_a;
        next_rdata[3:2] = 2'h0;
      end
      // force strobes and bits 7:4 read as zero
      `OFS_CTRL_B: begin
        next_rdata[`B_WGM_HI] = waveform_mode_high_bit;
        next_rdata[`B_CLK_SEL_HI:0] = clk_sel;
      end
      `OFS_COUNT: next_rdata = cnt;
      `OFS_CMP_A: next_rdata = cmp[0];
      `OFS_CMP_B: next_rdata = cmp[1];
      `OFS_STATUS: next_rdata = {5'h00, flags};
      `OFS_IRQ_EN: next_rdata = {5'h00, irq_en};
      `OFS_PORT: next_rdata = {2'h0, port_dir, 2'h0, port_data};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// [hw/timer2_params.svh]
/*
  timer2_params.svh: register offsets, field positions, reset values and
  fixed counter values for the timer waveform output control block.
  Assumes it is included by its bare name, once per compile unit.
*/
`ifndef TIMER2_PARAMS_SVH
`define TIMER2_PARAMS_SVH

// register offsets on the plain port
`define OFS_CTRL_A 4'h0
`define OFS_CTRL_B 4'h1
`define OFS_COUNT 4'h2
`define OFS_CMP_A 4'h3
`define OFS_CMP_B 4'h4
`define OFS_STATUS 4'h5
`define OFS_CLEAR 4'h6
`define OFS_IRQ_EN 4'h7
`define OFS_PORT 4'h8

// timer_control_b fields
`define B_FORCE_A 7
`define B_FORCE_B 6
`define B_WGM_HI 3
`define B_CLK_SEL_HI 2

// port register fields: data in 1:0, direction in 5:4
`define B_PORT_DIR_LO 4

// status, clear and enable fields
`define B_OVF 0
`define B_MATCH_A 1
`define B_MATCH_B 2

`define RST_BYTE 8'h00
`define CNT_MAX 8'hff
`define CNT_BOTTOM 8'h00

`endif

// [hw/timer2_pkg.sv]
/*
  timer2_pkg: types shared by the timer waveform output control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package timer2_pkg;

  typedef struct packed {
    logic [1:0] output_mode_a;
    logic [1:0] output_mode_b;
    logic [1:0] rsv;
    logic [1:0] waveform_mode_low_bits;
  } ctrl_a_t;

  typedef enum logic [2:0] {
    kind_normal,
    kind_ctc,
    kind_fast,
    kind_phase,
    kind_reserved
  } wave_kind_t;

endpackage

// [sim/pin_load.sv]
/*
  pin_load: external circuitry on one compare output pin.
  Assumes pin data and driver enable arrive from the block on mclk.
*/
`timescale 1ns/1ps
module pin_load (
  input wire logic mclk,
  input wire logic d,
  input wire logic oe,
  output logic lvl
);
  initial lvl = 1'b0;
  // a released pin has no pull: it never holds the last driven value
  always @(posedge mclk) begin
    lvl <= oe ? d : ~lvl;
  end
endmodule

// [sim/timer2_asserts.sv]
/*
  timer2_asserts: port-level checks for the waveform output control block.
  Assumes it is bound to the block and sees only its ports.
*/
`timescale 1ns/1ps
`include "timer2_params.svh"
module timer2_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic irq,
  input wire logic compare_pin_a,
  input wire logic compare_pin_a_oe,
  input wire logic compare_pin_b,
  input wire logic compare_pin_b_oe
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  sequence port_wr;
    wr && addr == `OFS_PORT ##1 !(wr && addr == `OFS_PORT);
  endsequence
  idle_read_a: assert property (!rd |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  ctrl_rsv_a: assert property (
    rd && addr == `OFS_CTRL_A |=> rdata[3:2] == 2'b00)
    else $error("reserved control bits read nonzero");
  force_rd_a: assert property (
    rd && addr == `OFS_CTRL_B |=> rdata[7:4] == 4'h0)
    else $error("force bits read nonzero");
  clear_rd_a: assert property (rd && addr == `OFS_CLEAR |=> rdata == 8'h00)
    else $error("clear register read nonzero");
  unmapped_a: assert property (rd && addr > `OFS_PORT |=> rdata == 8'h00)
    else $error("unmapped read nonzero");
  oe_a_a: assert property (
    port_wr |=> compare_pin_a_oe == $past(wdata[4], 2))
    else $error("pin a enable differs from direction bit");
  oe_b_a: assert property (
    port_wr |=> compare_pin_b_oe == $past(wdata[5], 2))
    else $error("pin b enable differs from direction bit");
  irq_mask_a: assert property (wr && addr == `OFS_IRQ_EN && wdata == 8'h00
    ##1 !(wr && addr == `OFS_IRQ_EN) |=> !irq)
    else $error("interrupt high while masked");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_b |=> !irq &&
    rdata == 8'h00 && !compare_pin_a_oe && !compare_pin_b_oe)
    else $error("outputs not quiet after reset");
  cover property (rd && addr == `OFS_CTRL_A);
  cover property (irq);
  cover property ($rose(compare_pin_a));
endmodule

bind timer2_waveform_output_control timer2_asserts u_chk (.mclk, .rst_b,
  .addr, .wdata, .wr, .rd, .rdata, .irq, .compare_pin_a, .compare_pin_a_oe,
  .compare_pin_b, .compare_pin_b_oe);

// [sim/testbench.sv]
/*
  testbench: register-level tests of the waveform output control block.
  Assumes the block, its package and the pin load model are compiled.
*/
`timescale 1ns/1ps
`include "timer2_params.svh"
module testbench
  import timer2_pkg::*;
;
  logic mclk = 0, rst_b = 0, wr = 0, rd = 0;
  logic [3:0] addr = 0;
  logic [7:0] wdata = 0, rdata, v;
  logic irq, compare_pin_a, compare_pin_a_oe, compare_pin_b;
  logic compare_pin_b_oe, lvl_a, lvl_b, p;
  int miscompares = 0, comparisons = 0, ha, hb;
  timer2_waveform_output_control uut (.mclk, .rst_b, .addr, .wdata, .wr,
    .rd, .rdata, .irq, .compare_pin_a, .compare_pin_a_oe, .compare_pin_b,
    .compare_pin_b_oe);
  pin_load load_a (.mclk, .d(compare_pin_a), .oe(compare_pin_a_oe),
    .lvl(lvl_a));
  pin_load load_b (.mclk, .d(compare_pin_b), .oe(compare_pin_b_oe),
    .lvl(lvl_b));
  initial begin
    forever #50 mclk = ~mclk;
  end
  function automatic logic [7:0] ca(int ma, mb, w);
    ctrl_a_t c;
    c = '{output_mode_a:2'(ma), output_mode_b:2'(mb), rsv:2'b00,
      waveform_mode_low_bits:2'(w)};
    return c;
  endfunction
  task chk(input string what, input logic [7:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chkr(input string what, input int lo, hi, got);
    comparisons++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("Error %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    d = rdata;
  endtask
  task run(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task duty(input int n);
    ha = 0;
    hb = 0;
    run(600);
    repeat (n) begin
      @(negedge mclk);
      ha += int'(lvl_a === 1'b1);
      hb += int'(lvl_b === 1'b1);
    end
  endtask
  task print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    miscompares++;
    print_verdict();
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    wreg(`OFS_CTRL_A, 8'hff);
    rreg(`OFS_CTRL_A, v);
    chk("ctrl a", 8'hf3, v);
    wreg(`OFS_CTRL_B, 8'hc9);
    rreg(`OFS_CTRL_B, v);
    chk("ctrl b", 8'h09, v);
    rreg(4'hf, v);
    chk("unmapped", 8'h00, v);
    rreg(`OFS_CLEAR, v);
    chk("clear reads zero", 8'h00, v);
    wreg(`OFS_CTRL_A, ca(0, 0, 0));
    wreg(`OFS_COUNT, 8'h5a);
    rreg(`OFS_COUNT, v);
    chk("halted count", 8'h5a, v);
    wreg(`OFS_PORT, 8'h33);
    run(3);
    chk("port pin a", 8'h01, {7'h0, lvl_a});
    wreg(`OFS_CMP_A, 8'h05);
    wreg(`OFS_CMP_B, 8'h09);
    wreg(`OFS_CTRL_B, 8'h01);
    for (int m = 2; m < 4; m++) begin
      wreg(`OFS_CTRL_A, ca(m, m, 0));
      run(300);
      chk("pin a", 8'(m - 2), {7'h0, lvl_a});
      chk("pin b", 8'(m - 2), {7'h0, lvl_b});
    end
    wreg(`OFS_CTRL_A, ca(1, 1, 0));
    wreg(`OFS_COUNT, 8'h10);
    run(3);
    p = lvl_a;
    run(255);
    chk("toggle a", {7'h0, ~p}, {7'h0, lvl_a});
    wreg(`OFS_CTRL_B, 8'h81);
    run(3);
    chk("force a", {7'h0, p}, {7'h0, lvl_a});
    wreg(`OFS_CLEAR, 8'h07);
    wreg(`OFS_IRQ_EN, 8'h01);
    run(260);
    chk("irq", 8'h01, {7'h0, irq});
    wreg(`OFS_IRQ_EN, 8'h00);
    run(1);
    chk("irq masked", 8'h00, {7'h0, irq});
    wreg(`OFS_CLEAR, 8'h01);
    rreg(`OFS_STATUS, v);
    chk("ovf cleared", 8'h00, v & 8'h01);
    wreg(`OFS_CMP_A, 8'h10);
    wreg(`OFS_COUNT, 8'h00);
    wreg(`OFS_CTRL_A, ca(0, 0, 2));
    wreg(`OFS_CLEAR, 8'h07);
    run(40);
    rreg(`OFS_STATUS, v);
    chk("ctc ovf", 8'h00, v & 8'h01);
    wreg(`OFS_CMP_B, 8'h08);
    wreg(`OFS_CTRL_B, 8'h09);
    wreg(`OFS_CTRL_A, ca(2, 2, 3));
    wreg(`OFS_CLEAR, 8'h07);
    run(20);
    rreg(`OFS_STATUS, v);
    chk("top ovf", 8'h01, v & 8'h01);
    duty(170);
    chkr("duty a", 170, 170, ha);
    chkr("duty b", 85, 95, hb);
    wreg(`OFS_CMP_A, 8'h80);
    wreg(`OFS_CMP_B, 8'hff);
    wreg(`OFS_CTRL_B, 8'h01);
    wreg(`OFS_CTRL_A, ca(3, 2, 3));
    duty(512);
    chkr("inverted a", 250, 258, ha);
    chkr("top b", 512, 512, hb);
    wreg(`OFS_PORT, 8'h30);
    wreg(`OFS_CTRL_A, ca(1, 1, 3));
    duty(300);
    chkr("off a", 0, 0, ha);
    chkr("off b", 0, 0, hb);
    wreg(`OFS_CMP_A, 8'h40);
    wreg(`OFS_CTRL_A, ca(2, 2, 1));
    duty(1020);
    chkr("phase a", 248, 264, ha);
    chkr("phase b", 1020, 1020, hb);
    print_verdict();
  end
endmodule
